// ==== rtl/eemac_pkg.sv ====
// constants, field layouts and bus carrier for the nonvolatile access controller
// assumes one 100 MHz clock and a plain one-cycle strobe register port
package eemac_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int EE_WRITE_TIME_NS = 4000000;
   localparam int EE_WRITE_CYCLES = (EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int REG_AW = 3;
   localparam int EE_DEPTH = 256;
   localparam int PROG_AW_MAX = 15;
   localparam int PROG_DW = 14;

   // register indices
   localparam logic [2:0] OFS_DATA_LOW = 3'h0;
   localparam logic [2:0] OFS_DATA_HIGH = 3'h1;
   localparam logic [2:0] OFS_ADDR_LOW = 3'h2;
   localparam logic [2:0] OFS_ADDR_HIGH = 3'h3;
   localparam logic [2:0] OFS_ACCESS_CONTROL = 3'h4;
   localparam logic [2:0] OFS_UNLOCK_KEY = 3'h5;
   localparam logic [2:0] OFS_FLAGS_TWO = 3'h6;

   // ee_access_control fields
   localparam int BIT_READ_TRIG = 0;
   localparam int BIT_WRITE_TRIG = 1;
   localparam int BIT_WRITE_ARM = 2;
   localparam int BIT_WRITE_ABORT = 3;
   localparam int BIT_CONFIG_SEL = 6;
   localparam int BIT_PROGRAM_SEL = 7;
   // peripheral_flags_two field
   localparam int BIT_WRITE_DONE = 4;

   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef struct packed {
      logic wrStrobe;
      logic rdStrobe;
      logic [REG_AW-1:0] addr;
      logic [7:0] wrData;
   } eemac_bus_s;

   typedef enum logic [1:0] {
      UNLOCK_NONE = 2'b00,
      UNLOCK_HALF = 2'b01,
      UNLOCK_FULL = 2'b11
   } eemac_unlock_e;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_BUSY = 2'b01,
      WR_FINISH = 2'b11
   } eemac_wrstate_e;

endpackage

// ==== rtl/eemac_ee_memory_access_control.sv ====
// nonvolatile access controller: indirect registers, unlock, timed writes, reads
// assumes all inputs come from logic on the same clock; config settings are static
`timescale 1ns/100ps

module eemac_ee_memory_access_control #(
   parameter int PROG_AW = 15,
   parameter int WRITE_CYCLES = eemac_pkg::EE_WRITE_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic deviceReset,
   input wire eemac_pkg::eemac_bus_s bus,
   output logic [7:0] rdData_r,
   output logic forcedNop_r,
   output logic writeBusy_r,
   output logic writeDoneFlag_r,
   input wire logic [1:0] selfWriteProtect,
   input wire logic programCodeProtect,
   input wire logic dataCodeProtect,
   input wire logic pgmRdStrobe,
   input wire logic pgmRdProgram,
   input wire logic [14:0] pgmRdAddr,
   output logic pgmRdValid_r,
   output logic pgmRdDenied_r,
   output logic [13:0] pgmRdData_r
);
   import eemac_pkg::*;

   localparam int CW = $clog2(WRITE_CYCLES + 1);
   localparam int PROG_DEPTH = 1 << PROG_AW;

   generate
      if (PROG_AW < 8 || PROG_AW > PROG_AW_MAX || WRITE_CYCLES < 1) begin : g_bad
         $error("eemac: unsupported PROG_AW or WRITE_CYCLES");
      end
   endgenerate

   // nonvolatile contents have no reset
   logic [7:0] eeMem [EE_DEPTH];
   logic [PROG_DW-1:0] progMem [PROG_DEPTH];

   logic [7:0] dataLow_r;
   logic [5:0] dataHigh_r;
   logic [7:0] addrLow_r;
   logic [6:0] addrHigh_r;
   logic programSel_r, configSel_r, writeArm_r, writeAbort_r;
   logic readTrig_r, writeTrig_r, readProg_r, readWait_r;
   eemac_unlock_e unlock_r, unlock_nxt;
   eemac_wrstate_e wrState_r, wrState_nxt;
   logic [CW-1:0] wrCount_r;
   logic wrProg_r, wrCfg_r;
   logic [14:0] wrAddr_r;
   logic [13:0] wrData_r;

   wire anyReset = reset | deviceReset;
   wire wrCtrl = bus.wrStrobe && bus.addr == OFS_ACCESS_CONTROL;
   wire wrKey = bus.wrStrobe && bus.addr == OFS_UNLOCK_KEY;
   wire wrFlags = bus.wrStrobe && bus.addr == OFS_FLAGS_TWO;
   wire [14:0] progAddr = {addrHigh_r, addrLow_r};
   wire [PROG_AW-1:0] progIdx = progAddr[PROG_AW-1:0];
   wire armNow = writeArm_r | bus.wrData[BIT_WRITE_ARM];
   // select bits written together with a trigger steer that same operation
   wire newProg = bus.wrData[BIT_PROGRAM_SEL];
   wire newCfg = bus.wrData[BIT_CONFIG_SEL];
   wire startWrite = wrCtrl && bus.wrData[BIT_WRITE_TRIG] && armNow &&
                     unlock_r == UNLOCK_FULL && wrState_r == WR_IDLE;
   wire startRead = wrCtrl && bus.wrData[BIT_READ_TRIG] && !readTrig_r;
   wire eeReadDone = readTrig_r && !readProg_r;
   wire progReadDone = readTrig_r && readProg_r && readWait_r;
   wire wrFinish = wrState_r == WR_FINISH;
   wire wrDoneSet = wrFinish;
   wire abortNow = deviceReset && !reset && wrState_r != WR_IDLE;

   // blocks below the boundary are locked; 11 leaves all of program memory writable
   function automatic logic isProtected(input logic [1:0] wrt, input logic [PROG_AW-1:0] a);
      logic [1:0] top;
      top = a[PROG_AW-1 -: 2];
      unique case (wrt)
         2'b11: isProtected = 1'b0;
         2'b10: isProtected = top == 2'b00;
         2'b01: isProtected = top[1] == 1'b0;
         2'b00: isProtected = 1'b1;
      endcase
   endfunction

   wire wrSuppressed = wrProg_r && isProtected(selfWriteProtect, wrAddr_r[PROG_AW-1:0]);

   // unlock tracking: any other register write breaks the sequence
   always_comb begin
      unlock_nxt = unlock_r;
      if (bus.wrStrobe) begin
         if (wrKey && bus.wrData == KEY_FIRST) begin
            unlock_nxt = UNLOCK_HALF;
         end else if (wrKey && bus.wrData == KEY_SECOND && unlock_r == UNLOCK_HALF) begin
            unlock_nxt = UNLOCK_FULL;
         end else begin
            unlock_nxt = UNLOCK_NONE;
         end
      end
   end

   always_comb begin
      wrState_nxt = wrState_r;
      unique case (wrState_r)
         WR_IDLE: if (startWrite) wrState_nxt = WR_BUSY;
         WR_BUSY: if (wrCount_r == CW'(WRITE_CYCLES - 1)) wrState_nxt = WR_FINISH;
         WR_FINISH: wrState_nxt = WR_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (anyReset) begin
         unlock_r <= UNLOCK_NONE;
         wrState_r <= WR_IDLE;
         wrCount_r <= '0;
      end else begin
         unlock_r <= unlock_nxt;
         wrState_r <= wrState_nxt;
         wrCount_r <= (wrState_r == WR_BUSY) ? wrCount_r + CW'(1) : '0;
      end
   end

   // write job latched at start so later register changes cannot disturb it
   always_ff @(posedge clock) begin
      if (anyReset) begin
         wrProg_r <= 1'b0;
         wrCfg_r <= 1'b0;
         wrAddr_r <= '0;
         wrData_r <= '0;
      end else if (startWrite) begin
         wrProg_r <= newProg;
         wrCfg_r <= newCfg;
         wrAddr_r <= newProg ? progAddr : {7'h00, addrLow_r};
         wrData_r <= {dataHigh_r, dataLow_r};
      end
   end

   // erase at start, program at the end of the timed cycle
   always_ff @(posedge clock) begin
      if (!anyReset && startWrite && !newProg && !newCfg) begin
         eeMem[addrLow_r] <= ERASED_BYTE;
      end else if (!anyReset && wrFinish && !wrProg_r && !wrCfg_r) begin
         eeMem[wrAddr_r[7:0]] <= wrData_r[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!anyReset && wrFinish && wrProg_r && !wrCfg_r && !wrSuppressed) begin
         progMem[wrAddr_r[PROG_AW-1:0]] <= wrData_r;
      end
   end

   // control bits
   always_ff @(posedge clock) begin
      if (anyReset) begin
         programSel_r <= 1'b0;
         configSel_r <= 1'b0;
         writeArm_r <= 1'b0;
      end else if (wrCtrl) begin
         programSel_r <= bus.wrData[BIT_PROGRAM_SEL];
         configSel_r <= bus.wrData[BIT_CONFIG_SEL];
         writeArm_r <= bus.wrData[BIT_WRITE_ARM];
      end
   end

   // abort flag survives the reset that caused it; power-up reset clears it and a control register write loads it from its BIT_WRITE_ABORT bit
   always_ff @(posedge clock) begin
      if (reset) begin
         writeAbort_r <= 1'b0;
      end else if (abortNow) begin
         writeAbort_r <= 1'b1;
      end else if (deviceReset) begin
         writeAbort_r <= writeAbort_r;
      end else if (wrCtrl) begin
         writeAbort_r <= bus.wrData[BIT_WRITE_ABORT];
      end
   end

   // write trigger: set only by a valid start, cleared by completion or by either reset
   always_ff @(posedge clock) begin
      if (anyReset) begin
         writeTrig_r <= 1'b0;
         writeBusy_r <= 1'b0;
      end else if (startWrite) begin
         writeTrig_r <= 1'b1;
         writeBusy_r <= 1'b1;
      end else if (wrFinish) begin
         writeTrig_r <= 1'b0;
         writeBusy_r <= 1'b0;
      end
   end

   // done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock) begin
      if (anyReset) begin
         writeDoneFlag_r <= 1'b0;
      end else if (wrDoneSet) begin
         writeDoneFlag_r <= 1'b1;
      end else if (wrFlags) begin
         writeDoneFlag_r <= bus.wrData[BIT_WRITE_DONE];
      end
   end

   // read trigger and program read stall
   always_ff @(posedge clock) begin
      if (anyReset) begin
         readTrig_r <= 1'b0;
         readProg_r <= 1'b0;
         readWait_r <= 1'b0;
         forcedNop_r <= 1'b0;
      end else begin
         if (startRead) begin
            readTrig_r <= 1'b1;
            readProg_r <= newProg;
         end else if (eeReadDone || progReadDone) begin
            readTrig_r <= 1'b0;
         end
         readWait_r <= readTrig_r && readProg_r && !readWait_r;
         forcedNop_r <= readTrig_r && readProg_r && !readWait_r;
      end
   end

   // config space is not modelled: its reads return zero
   wire [7:0] eeByte = configSel_r ? RST_BYTE : eeMem[addrLow_r];
   wire [13:0] progWord = configSel_r ? 14'h0000 : progMem[progIdx];

   // data registers: a completing read wins over a software write
   always_ff @(posedge clock) begin
      if (anyReset) begin
         dataLow_r <= RST_BYTE;
         dataHigh_r <= 6'h00;
      end else if (eeReadDone) begin
         dataLow_r <= eeByte;
      end else if (progReadDone) begin
         dataLow_r <= progWord[7:0];
         dataHigh_r <= progWord[13:8];
      end else if (bus.wrStrobe && bus.addr == OFS_DATA_LOW) begin
         dataLow_r <= bus.wrData;
      end else if (bus.wrStrobe && bus.addr == OFS_DATA_HIGH) begin
         dataHigh_r <= bus.wrData[5:0];
      end
   end

   always_ff @(posedge clock) begin
      if (anyReset) begin
         addrLow_r <= RST_BYTE;
         addrHigh_r <= 7'h00;
      end else if (bus.wrStrobe && bus.addr == OFS_ADDR_LOW) begin
         addrLow_r <= bus.wrData;
      end else if (bus.wrStrobe && bus.addr == OFS_ADDR_HIGH) begin
         addrHigh_r <= bus.wrData[6:0];
      end
   end

   // register read mux
   wire [7:0] ctrlView = {programSel_r, configSel_r, 2'b00, writeAbort_r, writeArm_r,
                          writeTrig_r, readTrig_r};
   logic [7:0] rdMux;
   always_comb begin
      unique case (bus.addr)
         OFS_DATA_LOW: rdMux = dataLow_r;
         OFS_DATA_HIGH: rdMux = {2'b00, dataHigh_r};
         OFS_ADDR_LOW: rdMux = addrLow_r;
         OFS_ADDR_HIGH: rdMux = {1'b0, addrHigh_r};
         OFS_ACCESS_CONTROL: rdMux = ctrlView;
         OFS_UNLOCK_KEY: rdMux = RST_BYTE;
         OFS_FLAGS_TWO: rdMux = {3'b000, writeDoneFlag_r, 4'h0};
         default: rdMux = RST_BYTE;
      endcase
   end

   // the only way in for the CPU is this register port
   always_ff @(posedge clock) begin
      if (anyReset) begin
         rdData_r <= RST_BYTE;
      end else if (bus.rdStrobe) begin
         rdData_r <= rdMux;
      end else begin
         rdData_r <= RST_BYTE;
      end
   end

   // external programmer read port, shut out by code protection
   wire pgmDenied = pgmRdProgram ? programCodeProtect : dataCodeProtect;
   wire [13:0] pgmWord = pgmRdProgram ? progMem[pgmRdAddr[PROG_AW-1:0]] :
                         {6'h00, eeMem[pgmRdAddr[7:0]]};
   always_ff @(posedge clock) begin
      if (anyReset) begin
         pgmRdValid_r <= 1'b0;
         pgmRdDenied_r <= 1'b0;
         pgmRdData_r <= 14'h0000;
      end else begin
         pgmRdValid_r <= pgmRdStrobe;
         pgmRdDenied_r <= pgmRdStrobe && pgmDenied;
         pgmRdData_r <= (pgmRdStrobe && !pgmDenied) ? pgmWord : 14'h0000;
      end
   end

endmodule

// ==== tb/eemac_chk.sv ====
// assertions for the nonvolatile access controller
// assumes the top ports only and a 5-cycle write timer in sim
`timescale 1ns/100ps
module eemac_chk
   import eemac_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic deviceReset,
   input wire eemac_pkg::eemac_bus_s bus,
   input wire logic [7:0] rdData_r,
   input wire logic forcedNop_r,
   input wire logic writeBusy_r,
   input wire logic writeDoneFlag_r,
   input wire logic programCodeProtect,
   input wire logic dataCodeProtect,
   input wire logic pgmRdStrobe,
   input wire logic pgmRdProgram,
   input wire logic pgmRdValid_r,
   input wire logic pgmRdDenied_r,
   input wire logic [13:0] pgmRdData_r
);
   wire trigWr = bus.wrStrobe && bus.addr == OFS_ACCESS_CONTROL && bus.wrData[BIT_WRITE_TRIG];
   wire pgmRdWr = bus.wrStrobe && bus.addr == OFS_ACCESS_CONTROL && bus.wrData[7] && bus.wrData[0];
   default clocking @(posedge clock); endclocking
   // an aborting reset cuts the timer short, so both resets disable
   default disable iff (reset || deviceReset);
   sequence busyRun;
      writeBusy_r [*5] ##[1:3] !writeBusy_r;
   endsequence
   a_read_window: assert property (!$past(bus.rdStrobe) |-> rdData_r == 8'h00)
      else $error("read data outside its cycle");
   a_key_reads_zero: assert property (bus.rdStrobe && bus.addr == OFS_UNLOCK_KEY |=> rdData_r == 8'h00)
      else $error("unlock key read not zero");
   a_write_cause: assert property ($rose(writeBusy_r) |-> $past(trigWr))
      else $error("write started without trigger");
   a_timer_length: assert property ($rose(writeBusy_r) |-> busyRun)
      else $error("write time wrong");
   a_done_set: assert property ($fell(writeBusy_r) |-> writeDoneFlag_r)
      else $error("done flag not set");
   a_forced_nop: assert property (forcedNop_r |-> $past(pgmRdWr, 2) ##1 !forcedNop_r)
      else $error("forced nop misplaced");
   a_pgm_answer: assert property (pgmRdStrobe |=> pgmRdValid_r
      && pgmRdDenied_r == $past(pgmRdProgram ? programCodeProtect : dataCodeProtect))
      else $error("programmer answer wrong");
   a_denied_blank: assert property (pgmRdDenied_r |-> pgmRdData_r == 14'h0000)
      else $error("denied read shows data");
endmodule

bind eemac_ee_memory_access_control eemac_chk u_eemac_chk (.clock, .reset, .deviceReset, .bus,
   .rdData_r, .forcedNop_r, .writeBusy_r, .writeDoneFlag_r, .programCodeProtect,
   .dataCodeProtect, .pgmRdStrobe, .pgmRdProgram, .pgmRdValid_r, .pgmRdDenied_r, .pgmRdData_r);

// ==== tb/eemac_ee_memory_access_control_tb.sv ====
// self-checking bench for the nonvolatile access controller
// assumes short write timer and 8-bit program address in sim
`timescale 1ns/100ps
module eemac_ee_memory_access_control_tb;
   import eemac_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic deviceReset = 1'b0;
   eemac_bus_s bus = '0;
   logic [1:0] selfWriteProtect = 2'b11;
   logic programCodeProtect = 1'b0;
   logic dataCodeProtect = 1'b1;
   logic pgmRdStrobe = 1'b0;
   logic pgmRdProgram = 1'b1;
   logic [14:0] pgmRdAddr = 15'h0010;
   logic [7:0] rdData_r;
   logic forcedNop_r, writeBusy_r, writeDoneFlag_r, pgmRdValid_r, pgmRdDenied_r;
   logic [13:0] pgmRdData_r;
   int error_cnt = 0;
   int compares = 0;
   always #5 clock = ~clock;
   eemac_ee_memory_access_control #(.PROG_AW(8), .WRITE_CYCLES(5)) u_eemac_ee_memory_access_control (
      .clock(clock), .reset(reset), .deviceReset(deviceReset), .bus(bus), .rdData_r(rdData_r),
      .forcedNop_r(forcedNop_r), .writeBusy_r(writeBusy_r), .writeDoneFlag_r(writeDoneFlag_r),
      .selfWriteProtect(selfWriteProtect), .programCodeProtect(programCodeProtect),
      .dataCodeProtect(dataCodeProtect), .pgmRdStrobe(pgmRdStrobe), .pgmRdProgram(pgmRdProgram),
      .pgmRdAddr(pgmRdAddr), .pgmRdValid_r(pgmRdValid_r), .pgmRdDenied_r(pgmRdDenied_r),
      .pgmRdData_r(pgmRdData_r));
   task results;
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // idle cycle after each access keeps one assignment per time step
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      bus <= '0;
   endtask
   task rdc(input logic [2:0] a, input logic [7:0] e);
      @(posedge clock);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      bus <= '0;
      #1 chk({8'h00, rdData_r}, {8'h00, e});
   endtask
   task unlock;
      wr(OFS_UNLOCK_KEY, KEY_FIRST);
      wr(OFS_UNLOCK_KEY, KEY_SECOND);
   endtask
   task waitIdle;
      int n;
      n = 0;
      #1;
      while (writeBusy_r !== 1'b0 && n < 40) begin
         @(posedge clock);
         n++;
      end
      if (n == 40) begin
         error_cnt++;
         results;
      end
   endtask
   task pgm(input logic [15:0] e);
      @(posedge clock);
      pgmRdStrobe <= 1'b1;
      @(posedge clock);
      pgmRdStrobe <= 1'b0;
      #1 chk({pgmRdValid_r, pgmRdDenied_r, pgmRdData_r}, e);
   endtask
   task s_reset_vals;
      rdc(OFS_ACCESS_CONTROL, 8'h00);
      rdc(OFS_UNLOCK_KEY, 8'h00);
      rdc(3'h7, 8'h00);
      rdc(OFS_FLAGS_TWO, 8'h00);
   endtask
   task s_ee_write;
      wr(OFS_ADDR_LOW, 8'hFF);
      wr(OFS_DATA_LOW, 8'hA5);
      unlock;
      wr(OFS_ACCESS_CONTROL, 8'h06);
      wr(OFS_ACCESS_CONTROL, 8'h00);
      rdc(OFS_ACCESS_CONTROL, 8'h02);
      waitIdle;
      chk({15'h0000, writeDoneFlag_r}, 16'h0001);
      rdc(OFS_ACCESS_CONTROL, 8'h00);
      rdc(OFS_FLAGS_TWO, 8'h10);
      wr(OFS_FLAGS_TWO, 8'h00);
      rdc(OFS_FLAGS_TWO, 8'h00);
      wr(OFS_DATA_LOW, 8'h00);
      wr(OFS_ACCESS_CONTROL, 8'h01);
      rdc(OFS_DATA_LOW, 8'hA5);
   endtask
   task s_bad_order;
      wr(OFS_UNLOCK_KEY, KEY_SECOND);
      wr(OFS_UNLOCK_KEY, KEY_FIRST);
      wr(OFS_ACCESS_CONTROL, 8'h06);
      rdc(OFS_ACCESS_CONTROL, 8'h04);
      unlock;
      wr(OFS_ADDR_LOW, 8'hFF);
      wr(OFS_ACCESS_CONTROL, 8'h06);
      rdc(OFS_ACCESS_CONTROL, 8'h04);
      wr(OFS_ACCESS_CONTROL, 8'h00);
      unlock;
      wr(OFS_ACCESS_CONTROL, 8'h02);
      rdc(OFS_ACCESS_CONTROL, 8'h00);
   endtask
   task s_prog;
      wr(OFS_ADDR_HIGH, 8'h00);
      wr(OFS_ADDR_LOW, 8'h10);
      wr(OFS_DATA_HIGH, 8'h3F);
      wr(OFS_DATA_LOW, 8'h5A);
      unlock;
      wr(OFS_ACCESS_CONTROL, 8'h86);
      waitIdle;
      selfWriteProtect <= 2'b00;
      wr(OFS_DATA_HIGH, 8'h00);
      wr(OFS_DATA_LOW, 8'h00);
      unlock;
      wr(OFS_ACCESS_CONTROL, 8'h86);
      waitIdle;
      wr(OFS_ACCESS_CONTROL, 8'h81);
      @(posedge clock);
      #1 chk({15'h0000, forcedNop_r}, 16'h0001);
      rdc(OFS_DATA_HIGH, 8'h3F);
      rdc(OFS_DATA_LOW, 8'h5A);
      pgm(16'hBF5A);
      programCodeProtect <= 1'b1;
      pgm(16'hC000);
      pgmRdProgram <= 1'b0;
      pgmRdAddr <= 15'h00FF;
      pgm(16'hC000);
   endtask
   task s_abort;
      wr(OFS_ACCESS_CONTROL, 8'h00);
      unlock;
      wr(OFS_ACCESS_CONTROL, 8'h06);
      deviceReset <= 1'b1;
      repeat (2) @(posedge clock);
      deviceReset <= 1'b0;
      rdc(OFS_ACCESS_CONTROL, 8'h08);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      s_reset_vals;
      s_ee_write;
      s_bad_order;
      s_prog;
      s_abort;
      results;
   end
endmodule
